// ---- rtl/module_sleep_wake_control.sv ----
`timescale 1ns/1ps
module module_sleep_wake_control #(
	parameter int MS_CYC        = sleep_wake_pkg::MS_CYC,
	parameter int POLL_WAKE_CYC = sleep_wake_pkg::POLL_WAKE_CYC,
	parameter int CHAR_CYC      = sleep_wake_pkg::CHAR_CYC,
	parameter int POLL_INT_CYC  = sleep_wake_pkg::POLL_INT_CYC
) (
	// clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        SYS_RST_I,
	// wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// pins from host
	input  wire logic        SLEEP_REQUEST_PIN_I,
	input  wire logic        SPI_SELECT_PIN_I,
	input  wire logic        COMMISSION_BUTTON_PIN_I,
	// work status from core logic
	input  wire logic        CMD_MODE_I,
	input  wire logic        ESCAPE_PARTIAL_I,
	input  wire logic        CONFIG_BUSY_I,
	input  wire logic        SERIAL_OUT_QUEUED_I,
	input  wire logic        RTS_HOLD_I,
	input  wire logic        RADIO_TX_PENDING_I,
	input  wire logic        XFER_ACTIVE_I,
	input  wire logic        DATA_RX_I,
	// outputs
	output logic             CTS_N_O,
	output logic             AWAKE_O,
	output logic             POLL_O,
	output logic             BUTTON_PRESS_O
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [2:0] pins;
	logic [2:0] pins_q;
	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			sync_a <= 3'h7;
			sync_b <= 3'h7;
			pins_q <= 3'h7;
		end else begin
			sync_a <= {COMMISSION_BUTTON_PIN_I, SPI_SELECT_PIN_I, SLEEP_REQUEST_PIN_I};
			sync_b <= sync_a;
			pins_q <= sync_b;
		end
	end
	assign pins = sync_b;

	// ****************************************
	// edge detect settling
	// ****************************************
	// pins_q holds reset ones until real samples arrive,
	// so edges are ignored until the pipe has filled
	logic [1:0] settle;
	logic [1:0] next_settle;
	logic       pins_ok;

	always_comb begin
		next_settle = settle;
		if (settle != 2'h3) begin
			next_settle = settle + 2'h1;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			settle <= 2'h0;
		end else begin
			settle <= next_settle;
		end
	end

	assign pins_ok = settle == 2'h3;

	// ****************************************
	// registers
	// ****************************************
	logic [3:0]  sleep_mode_setting;
	logic [31:0] wake_time_setting;
	logic [31:0] sleep_period_setting;
	logic [31:0] ctrl;
	logic [3:0]  next_mode;
	logic [31:0] next_wake;
	logic [31:0] next_period;
	logic [31:0] next_ctrl;
	logic [31:0] next_dat;
	logic        next_ack;
	logic [31:0] status;
	logic        wr;
	logic        pin8_function;
	logic        flow_ctl_pin_function;
	logic        button_fn;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// write lands on the edge at which the master sees ack
	assign wr                    = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
	assign pin8_function         = ctrl[sleep_wake_pkg::CTRL_PIN8_FN];
	assign flow_ctl_pin_function = ctrl[sleep_wake_pkg::CTRL_FLOW_FN];
	assign button_fn             = ctrl[sleep_wake_pkg::CTRL_BTN_FN];

	always_comb begin
		next_mode   = sleep_mode_setting;
		next_wake   = wake_time_setting;
		next_period = sleep_period_setting;
		next_ctrl   = ctrl;
		next_ack    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
		next_dat    = 32'h00000000;
		if (wr && WB_ADR_I == sleep_wake_pkg::ADDR_MODE) begin
			next_mode = 4'(merge({28'h0000000, sleep_mode_setting}, WB_DAT_I, WB_SEL_I));
		end else if (wr && WB_ADR_I == sleep_wake_pkg::ADDR_WAKE) begin
			next_wake = merge(wake_time_setting, WB_DAT_I, WB_SEL_I);
		end else if (wr && WB_ADR_I == sleep_wake_pkg::ADDR_PERIOD) begin
			next_period = merge(sleep_period_setting, WB_DAT_I, WB_SEL_I);
		end else if (wr && WB_ADR_I == sleep_wake_pkg::ADDR_CTRL) begin
			next_ctrl = merge(ctrl, WB_DAT_I, WB_SEL_I) & 32'h0000001f;
		end
		if (WB_ADR_I == sleep_wake_pkg::ADDR_MODE) begin
			next_dat = {28'h0000000, sleep_mode_setting};
		end else if (WB_ADR_I == sleep_wake_pkg::ADDR_WAKE) begin
			next_dat = wake_time_setting;
		end else if (WB_ADR_I == sleep_wake_pkg::ADDR_PERIOD) begin
			next_dat = sleep_period_setting;
		end else if (WB_ADR_I == sleep_wake_pkg::ADDR_CTRL) begin
			next_dat = ctrl;
		end else if (WB_ADR_I == sleep_wake_pkg::ADDR_STATUS) begin
			next_dat = status;
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			sleep_mode_setting   <= sleep_wake_pkg::MODE_NONE;
			wake_time_setting    <= sleep_wake_pkg::WAKE_RESET;
			sleep_period_setting <= sleep_wake_pkg::PERIOD_RESET;
			ctrl                 <= sleep_wake_pkg::CTRL_RESET;
			WB_ACK_O             <= 1'b0;
			WB_DAT_O             <= 32'h00000000;
		end else begin
			sleep_mode_setting   <= next_mode;
			wake_time_setting    <= next_wake;
			sleep_period_setting <= next_period;
			ctrl                 <= next_ctrl;
			WB_ACK_O             <= next_ack;
			WB_DAT_O             <= next_dat;
		end
	end

	// ****************************************
	// sleep sequencer
	// ****************************************
	typedef enum logic [1:0] {AWAKE, IDLE, ASLEEP} state_e;
	state_e      state;
	state_e      next_state;
	logic [31:0] wake_cnt;
	logic [31:0] next_wake_cnt;
	logic [31:0] sleep_cnt;
	logic [31:0] next_sleep_cnt;
	logic [31:0] poll_cnt;
	logic [31:0] next_poll_cnt;
	logic [31:0] lat_wake;
	logic [31:0] lat_period;
	logic [31:0] next_lat_wake;
	logic [31:0] next_lat_period;
	logic        first_poll;
	logic        next_first_poll;
	logic        next_poll;
	logic        next_button;
	logic        rq;
	logic        rq_q;
	logic        pin_mode;
	logic        cyc_mode;
	logic        blocked;
	logic        btn_act;
	logic [31:0] st_cyc;
	logic [31:0] sp_cyc;

	assign rq       = pin8_function ? pins[0] : pins[1]; // R3
	assign rq_q     = pin8_function ? pins_q[0] : pins_q[1];
	assign pin_mode = sleep_mode_setting == sleep_wake_pkg::MODE_PIN;
	assign cyc_mode = sleep_mode_setting == sleep_wake_pkg::MODE_CYCLIC
	               || sleep_mode_setting == sleep_wake_pkg::MODE_CYCLIC_PW;
	assign btn_act  = button_fn && pins_ok && (pins[2] != pins_q[2]); // R6
	// latched copies so timing writes wait for the next wake
	assign st_cyc   = 32'(lat_wake * 32'(MS_CYC)); // R17
	assign sp_cyc   = 32'(lat_period * 32'(MS_CYC));
	assign blocked  = CMD_MODE_I || ESCAPE_PARTIAL_I // R7
	               || CONFIG_BUSY_I // R8
	               || (SERIAL_OUT_QUEUED_I && !RTS_HOLD_I) // R9
	               || RADIO_TX_PENDING_I // R14
	               || (pin_mode && !rq) // R13 R1
	               || wake_cnt != 32'h00000000; // R20
	assign status   = {26'h0000000, rq, blocked, state == ASLEEP, state == IDLE, state == AWAKE, 1'b0};

	always_comb begin
		next_state      = state;
		next_wake_cnt   = (wake_cnt != 32'h00000000) ? wake_cnt - 32'h00000001 : wake_cnt;
		next_sleep_cnt  = sleep_cnt;
		next_poll_cnt   = poll_cnt;
		next_lat_wake   = lat_wake;
		next_lat_period = lat_period;
		next_first_poll = first_poll;
		next_poll       = 1'b0;
		next_button     = btn_act;
		case (state)
			AWAKE: begin
				if (DATA_RX_I && cyc_mode) begin
					next_wake_cnt = wake_cnt + st_cyc; // R12 R15
				end
				if (sleep_mode_setting == sleep_wake_pkg::MODE_CYCLIC_PW && !rq) begin
					next_wake_cnt = (wake_cnt > st_cyc) ? next_wake_cnt : st_cyc;
				end
				if (ctrl[sleep_wake_pkg::CTRL_POLLER] && cyc_mode) begin
					if (first_poll || poll_cnt == 32'h00000000) begin // R16
						next_poll       = 1'b1;
						next_first_poll = 1'b0;
						next_poll_cnt   = 32'(POLL_INT_CYC);
					end else begin
						next_poll_cnt = poll_cnt - 32'h00000001;
					end
				end
				if ((pin_mode || cyc_mode) && !blocked) begin
					next_state = IDLE; // R20
				end
			end
			IDLE: begin
				// transfers must drain before the clock stops
				if (blocked || XFER_ACTIVE_I) begin // R18
					next_state = AWAKE;
				end else begin
					next_state     = ASLEEP;
					next_sleep_cnt = sp_cyc;
				end
			end
			default: begin
				next_sleep_cnt = (sleep_cnt != 32'h00000000) ? sleep_cnt - 32'h00000001 : sleep_cnt;
				if ((pin_mode && (!rq || btn_act)) // R1 R6
				    || (sleep_mode_setting == sleep_wake_pkg::MODE_CYCLIC_PW && pins_ok && !rq && rq_q) // R2
				    || (cyc_mode && sleep_cnt == 32'h00000000)
				    || !(pin_mode || cyc_mode)) begin
					next_state      = AWAKE;
					next_lat_wake   = wake_time_setting; // R17
					next_lat_period = sleep_period_setting;
					next_first_poll = 1'b1;
					next_poll_cnt   = 32'(POLL_INT_CYC);
					if (pin_mode) begin
						next_wake_cnt = 32'(CHAR_CYC); // R10
					end else if (ctrl[sleep_wake_pkg::CTRL_OPT_FULL]
					             || (sleep_mode_setting == sleep_wake_pkg::MODE_CYCLIC_PW && !rq)) begin
						next_wake_cnt = 32'(wake_time_setting * 32'(MS_CYC)); // R11
					end else if (ctrl[sleep_wake_pkg::CTRL_POLLER]) begin
						next_wake_cnt = 32'(POLL_WAKE_CYC); // R11
					end else begin
						next_wake_cnt = 32'h00000001;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			state          <= AWAKE;
			wake_cnt       <= 32'h00000000;
			sleep_cnt      <= 32'h00000000;
			poll_cnt       <= 32'h00000000;
			lat_wake       <= sleep_wake_pkg::WAKE_RESET;
			lat_period     <= sleep_wake_pkg::PERIOD_RESET;
			first_poll     <= 1'b1;
			POLL_O         <= 1'b0;
			BUTTON_PRESS_O <= 1'b0;
		end else begin
			state          <= next_state;
			wake_cnt       <= next_wake_cnt;
			sleep_cnt      <= next_sleep_cnt;
			poll_cnt       <= next_poll_cnt;
			lat_wake       <= next_lat_wake;
			lat_period     <= next_lat_period;
			first_poll     <= next_first_poll;
			POLL_O         <= next_poll;
			BUTTON_PRESS_O <= next_button;
		end
	end

	// ****************************************
	// host indicators
	// ****************************************
	assign CTS_N_O = flow_ctl_pin_function ? (state != AWAKE) : 1'b0; // R4 R19
	assign AWAKE_O = state == AWAKE; // R5
endmodule // module_sleep_wake_control

// ---- rtl/sleep_wake_pkg.sv ----
// Overview of operation
// R1 - pin sleep: request high sleeps, low wakes
// R2 - mode 5: falling edge wakes for wake time
// R3 - pin8 function zero: select pin acts as request
// R4 - flow function one: cts high asleep, low awake
// R5 - awake indicator low asleep, high ready
// R6 - button function wakes device from pin sleep
// R7 - no sleep in command mode or escape
// R8 - no sleep while executing configuration commands
// R9 - no sleep with unblocked serial output queued
// R10 - pin sleep: stay awake one character time
// R11 - cyclic minimum wake: wake time or 30 ms; code can wake one cycle with CTRL_OPT_FULL and CTRL_POLLER clear
// R12 - new data extends wake by wake time
// R13 - pin sleep: awake while request deasserted
// R14 - no sleep while radio data waits
// R15 - modes 4/5: data starts sleep countdown timer
// R16 - poller polls after waking, then regularly
// R17 - timing changes apply at next wake
// R18 - finish transfers, pass idle before sleep
// R19 - cts low only when able to transfer
// R20 - sleep only when all blockers false
package sleep_wake_pkg;
	// ****************************************
	// sleep modes
	// ****************************************
	localparam logic [3:0] MODE_NONE      = 4'h0;
	localparam logic [3:0] MODE_PIN       = 4'h1;
	localparam logic [3:0] MODE_CYCLIC    = 4'h4;
	localparam logic [3:0] MODE_CYCLIC_PW = 4'h5;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_MODE   = 8'h00;
	localparam logic [7:0] ADDR_WAKE   = 8'h04;
	localparam logic [7:0] ADDR_PERIOD = 8'h08;
	localparam logic [7:0] ADDR_CTRL   = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	// ctrl field positions
	localparam int CTRL_PIN8_FN  = 0;
	localparam int CTRL_FLOW_FN  = 1;
	localparam int CTRL_BTN_FN   = 2;
	localparam int CTRL_OPT_FULL = 3;
	localparam int CTRL_POLLER   = 4;
	localparam logic [31:0] CTRL_RESET   = 32'h00000006;
	localparam logic [31:0] WAKE_RESET   = 32'h00000064;
	localparam logic [31:0] PERIOD_RESET = 32'h00000064;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ       = 250;
	localparam int POLL_WAKE_MS  = 30;
	localparam int POLL_WAKE_CYC = POLL_WAKE_MS * 1000 * CLK_MHZ;
	localparam int MS_CYC        = 1000 * CLK_MHZ;
	localparam int CHAR_US       = 1042;
	localparam int CHAR_CYC      = CHAR_US * CLK_MHZ;
	localparam int POLL_INT_MS   = 100;
	localparam int POLL_INT_CYC  = POLL_INT_MS * MS_CYC;
endpackage : sleep_wake_pkg

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
module host_model (
	// requests from bench
	input  wire logic want_sleep_i,
	input  wire logic send_i,
	// device status
	input  wire logic cts_n_i,
	// pins to device
	output logic      sleep_pin_o,
	output logic      data_rx_o
);
	// level control, high sleeps, low wakes
	assign sleep_pin_o = want_sleep_i;
	// data dropped while cts is high, so it only reaches the device while cts is low
	assign data_rx_o = send_i & ~cts_n_i;
endmodule // host_model

// ---- tb/sleep_wake_checker.sv ----
`timescale 1ns/1ps
module sleep_wake_checker (
	// clock, reset, bus
	input wire logic CORE_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_ACK_O,
	// blockers
	input wire logic CMD_MODE_I,
	input wire logic ESCAPE_PARTIAL_I,
	input wire logic CONFIG_BUSY_I,
	input wire logic SERIAL_OUT_QUEUED_I,
	input wire logic RTS_HOLD_I,
	input wire logic RADIO_TX_PENDING_I,
	input wire logic XFER_ACTIVE_I,
	// status
	input wire logic CTS_N_O,
	input wire logic AWAKE_O,
	input wire logic POLL_O,
	input wire logic BUTTON_PRESS_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
	cts_asleep_a: assert property (CTS_N_O |-> !AWAKE_O) else $error("cts high while awake");
	cmd_hold_a: assert property (AWAKE_O && (CMD_MODE_I || ESCAPE_PARTIAL_I) |=> AWAKE_O) else $error("cmd");
	cfg_hold_a: assert property (AWAKE_O && CONFIG_BUSY_I |=> AWAKE_O) else $error("config");
	out_hold_a: assert property (AWAKE_O && SERIAL_OUT_QUEUED_I && !RTS_HOLD_I |=> AWAKE_O) else $error("out");
	radio_hold_a: assert property (AWAKE_O && RADIO_TX_PENDING_I |=> AWAKE_O) else $error("radio");
	xfer_idle_a: assert property ($fell(AWAKE_O) && XFER_ACTIVE_I |=> AWAKE_O) else $error("xfer");
	btn_pulse_a: assert property (BUTTON_PRESS_O |=> !BUTTON_PRESS_O) else $error("button");
	poll_pulse_a: assert property (POLL_O |=> !POLL_O) else $error("poll");
endmodule // sleep_wake_checker
bind module_sleep_wake_control sleep_wake_checker u_chk (.CORE_CLK_I, .SYS_RST_I, .WB_CYC_I, .WB_STB_I,
	.WB_ACK_O, .CMD_MODE_I, .ESCAPE_PARTIAL_I, .CONFIG_BUSY_I, .SERIAL_OUT_QUEUED_I, .RTS_HOLD_I,
	.RADIO_TX_PENDING_I, .XFER_ACTIVE_I, .CTS_N_O, .AWAKE_O, .POLL_O, .BUTTON_PRESS_O);

// ---- tb/module_sleep_wake_control_tb_top.sv ----
`timescale 1ns/1ps
module module_sleep_wake_control_tb_top;
	logic        clk = 1'h0, rst = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
	logic        want = 1'h1, spi = 1'h1, btn = 1'h0, send = 1'h0, seen;
	logic [7:0]  adr = 8'h00;
	logic [6:0]  blk = 7'h00;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic        ack, cts_n, awake, poll, bpress, pin, drx;
	int          failures = 0, cmp_count = 0, n;
	module_sleep_wake_control #(.MS_CYC(10), .POLL_WAKE_CYC(30), .CHAR_CYC(20), .POLL_INT_CYC(50)) u_dut (
		.CORE_CLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SLEEP_REQUEST_PIN_I(pin),
		.SPI_SELECT_PIN_I(spi), .COMMISSION_BUTTON_PIN_I(btn), .CMD_MODE_I(blk[0]), .ESCAPE_PARTIAL_I(blk[1]),
		.CONFIG_BUSY_I(blk[2]), .SERIAL_OUT_QUEUED_I(blk[3]), .RTS_HOLD_I(blk[4]), .RADIO_TX_PENDING_I(blk[5]),
		.XFER_ACTIVE_I(blk[6]), .DATA_RX_I(drx), .CTS_N_O(cts_n), .AWAKE_O(awake), .POLL_O(poll),
		.BUTTON_PRESS_O(bpress));
	host_model u_host (.want_sleep_i(want), .send_i(send), .cts_n_i(cts_n), .sleep_pin_o(pin), .data_rx_o(drx));
	initial forever #2 clk = ~clk;
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic finish_test;
		$display("failures %0d compares %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'h1 && i < 20);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		check(32'(ack), 32'h1);
	endtask
	task automatic wait_aw(input logic v, input int lim);
		int i;
		i = 0;
		while (awake !== v && i < lim) begin
			@(posedge clk);
			i++;
		end
		check(32'(awake), 32'(v));
	endtask
	task automatic awake_len;
		n = 0;
		while (awake === 1'h1 && n < 3000) begin
			n++;
			@(posedge clk);
		end
	endtask
	// one-cycle low pulse on the request pin
	task automatic pulse_wake;
		want <= 1'h0;
		tick(1);
		want <= 1'h1;
		wait_aw(1'h1, 10);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs;
		bus(1'h0, sleep_wake_pkg::ADDR_CTRL, 32'h0);
		check(q, sleep_wake_pkg::CTRL_RESET);
		bus(1'h0, sleep_wake_pkg::ADDR_WAKE, 32'h0);
		check(q, sleep_wake_pkg::WAKE_RESET);
		bus(1'h0, sleep_wake_pkg::ADDR_PERIOD, 32'h0);
		check(q, sleep_wake_pkg::PERIOD_RESET);
		bus(1'h1, 8'h20, 32'hffffffff);
		bus(1'h0, 8'h20, 32'h0);
		check(q, 32'h0);
	endtask
	task automatic t_pin;
		bus(1'h1, sleep_wake_pkg::ADDR_WAKE, 32'h2);
		bus(1'h1, sleep_wake_pkg::ADDR_CTRL, 32'h7);
		bus(1'h1, sleep_wake_pkg::ADDR_MODE, 32'(sleep_wake_pkg::MODE_PIN));
		wait_aw(1'h0, 200);
		check(32'(cts_n), 32'h1);
		pulse_wake;
		check(32'(cts_n), 32'h0);
		awake_len;
		check(32'(n >= 20), 32'h1);
		want <= 1'h0;
		wait_aw(1'h1, 10);
		tick(100);
		check(32'(awake), 32'h1);
		want <= 1'h1;
		wait_aw(1'h0, 200);
	endtask
	task automatic t_block;
		logic [6:0] tab [6];
		tab = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h20, 7'h18};
		for (int i = 0; i < 6; i++) begin
			blk <= tab[i];
			pulse_wake;
			tick(100);
			check(32'(awake), 32'(i < 5));
			blk <= 7'h00;
			wait_aw(1'h0, 200);
		end
		blk <= 7'h40;
		pulse_wake;
		tick(60);
		bus(1'h0, sleep_wake_pkg::ADDR_STATUS, 32'h0);
		check(32'(q[3]), 32'h0);
		blk <= 7'h00;
		wait_aw(1'h0, 200);
	endtask
	task automatic t_spi;
		bus(1'h1, sleep_wake_pkg::ADDR_CTRL, 32'h6);
		want <= 1'h0;
		tick(10);
		check(32'(awake), 32'h0);
		spi <= 1'h0;
		wait_aw(1'h1, 10);
		spi <= 1'h1;
		wait_aw(1'h0, 200);
		bus(1'h1, sleep_wake_pkg::ADDR_CTRL, 32'h4);
		tick(1);
		check(32'(cts_n), 32'h0);
		want <= 1'h1;
		bus(1'h1, sleep_wake_pkg::ADDR_CTRL, 32'h7);
		wait_aw(1'h0, 200);
	endtask
	task automatic t_btn;
		seen = 1'h0;
		btn <= ~btn;
		repeat (10) begin
			@(posedge clk);
			seen |= bpress;
		end
		check(32'(seen), 32'h1);
		check(32'(awake), 32'h1);
		wait_aw(1'h0, 200);
	endtask
	task automatic t_cyc5;
		bus(1'h1, sleep_wake_pkg::ADDR_MODE, 32'(sleep_wake_pkg::MODE_CYCLIC_PW));
		pulse_wake;
		awake_len;
		check(32'(n >= 20), 32'h1);
		pulse_wake;
		tick(9);
		send <= 1'h1;
		tick(1);
		send <= 1'h0;
		awake_len;
		check(32'(n + 10 >= 35), 32'h1);
	endtask
	task automatic t_poll;
		bus(1'h1, sleep_wake_pkg::ADDR_CTRL, 32'h17);
		bus(1'h1, sleep_wake_pkg::ADDR_MODE, 32'(sleep_wake_pkg::MODE_CYCLIC));
		wait_aw(1'h0, 200);
		wait_aw(1'h1, 1500);
		seen = 1'h0;
		repeat (3) begin
			@(posedge clk);
			seen |= poll;
		end
		check(32'(seen), 32'h1);
		awake_len;
		check(32'(n + 3 >= 30), 32'h1);
	endtask
	initial begin
		tick(10);
		rst <= 1'h0;
		t_regs;
		t_pin;
		t_block;
		t_spi;
		t_btn;
		t_cyc5;
		t_poll;
		finish_test;
	end
	// whole run needs well under this many cycles
	initial begin
		tick(20000);
		failures++;
		finish_test;
	end
endmodule // module_sleep_wake_control_tb_top
